// *** include/ami_defines.svh ***
// Constants for the asynchronous memory interface controller.
// Assumes inclusion by bare name from design files.
`ifndef AMI_DEFINES_SVH
`define AMI_DEFINES_SVH
`define AMI_NUM_CS 4
`define AMI_ADDR_W 24
`define AMI_DATA_W 16
`define AMI_PHASE_W 4
// Field layout of a region_async_config word
`define AMI_CFG_W 15
`define AMI_CFG_SETUP_LSB 0
`define AMI_CFG_STROBE_LSB 4
`define AMI_CFG_HOLD_LSB 8
`define AMI_CFG_EW_BIT 12
`define AMI_CFG_WPOL_BIT 13
`define AMI_CFG_WIDE_BIT 14
// Reset value: setup 1, strobe 2, hold 2, 16-bit bus, wait active low
`define AMI_CFG_RESET 15'h4221
`define AMI_CS_IDLE 4'hf
`define AMI_ONE_PHASE 4'h1
`define AMI_WAIT_TIMEOUT_NS 40960
`define AMI_CLOCK_NS 10
`endif

// *** include/ami_pkg.sv ***
// Types shared by the asynchronous memory interface controller.
// Assumes nothing beyond a SystemVerilog compiler.
package ami_pkg;
  typedef enum logic [2:0] {
    AMI_IDLE,
    AMI_SETUP,
    AMI_STROBE,
    AMI_EXT_WAIT,
    AMI_HOLD
  } ami_state_e;
endpackage

// *** hw/ami_ctrl.sv ***
// Asynchronous external memory controller: SRAM, NOR flash, ROM.
// Assumes a user port on the same clock; region configuration as plain inputs.
`timescale 1ns/1ps
`include "ami_defines.svh"

module ami_ctrl #(
  parameter int ADDR_W = `AMI_ADDR_W,
  parameter int DATA_W = `AMI_DATA_W,
  parameter int NUM_CS = `AMI_NUM_CS,
  parameter int WAIT_TIMEOUT_CYC = `AMI_WAIT_TIMEOUT_NS / `AMI_CLOCK_NS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // User request port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_region,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic rsp_timeout,
  // Per-region configuration
  input wire logic [NUM_CS-1:0][`AMI_CFG_W-1:0] region_async_config,
  // Memory pins
  output logic [ADDR_W-1:0] ext_addr_bus,
  input wire logic [DATA_W-1:0] ext_data_in,
  output logic [DATA_W-1:0] ext_data_out,
  output logic ext_data_oe,
  output logic [NUM_CS-1:0] chip_enable_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic rd_wr_select,
  input wire logic [NUM_CS-1:0] ext_wait_in
);
  // Timeout counter is 16 bits wide; larger limits would silently wrap
  if (DATA_W != `AMI_DATA_W || NUM_CS != `AMI_NUM_CS || ADDR_W < 1 || ADDR_W > `AMI_ADDR_W ||
      WAIT_TIMEOUT_CYC < 1 || WAIT_TIMEOUT_CYC > 65535) begin : g_param_check
    $error("ami_ctrl: unsupported parameters");
  end

  function automatic logic [`AMI_PHASE_W-1:0] phase_len(input logic [`AMI_CFG_W-1:0] c,
                                                       input int lsb);
    logic [`AMI_PHASE_W-1:0] v;
    v = c[lsb +: `AMI_PHASE_W];
    phase_len = (v == '0) ? `AMI_ONE_PHASE : v;
  endfunction

  // Wait pins come from outside; two flops each
  logic [NUM_CS-1:0] wait_s1_q, wait_s2_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      wait_s1_q <= '0;
      wait_s2_q <= '0;
    end else begin
      wait_s1_q <= ext_wait_in;
      wait_s2_q <= wait_s1_q;
    end
  end

  ami_pkg::ami_state_e state_q, state_d;
  logic [`AMI_PHASE_W-1:0] cnt_q, cnt_d;
  logic [15:0] tmo_q, tmo_d;
  logic [1:0] reg_q, reg_d;
  logic wr_q, wr_d;
  logic [`AMI_CFG_W-1:0] cfg_q, cfg_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic [NUM_CS-1:0] cs_n_q, cs_n_d;
  logic oe_n_q, oe_n_d, we_n_q, we_n_d, rw_q, rw_d, doe_q, doe_d;
  logic ready_q, ready_d, rv_q, rv_d, tmo_flag_q, tmo_flag_d;
  logic wait_act, wide;

  // Polarity bit selects the active level of the region's wait
  assign wait_act = wait_s2_q[reg_q] == cfg_q[`AMI_CFG_WPOL_BIT];
  assign wide = cfg_q[`AMI_CFG_WIDE_BIT];

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    tmo_d = tmo_q;
    reg_d = reg_q;
    wr_d = wr_q;
    cfg_d = cfg_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    cs_n_d = cs_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    rw_d = rw_q;
    doe_d = doe_q;
    ready_d = ready_q;
    rv_d = 1'b0;
    tmo_flag_d = tmo_flag_q;
    case (state_q)
      ami_pkg::AMI_IDLE: begin
        if (req_valid && ready_q) begin
          reg_d = req_region;
          wr_d = req_write;
          cfg_d = region_async_config[req_region];
          addr_d = req_addr;
          // Narrow region uses the low byte lane only
          wdat_d = region_async_config[req_region][`AMI_CFG_WIDE_BIT] ? req_wdata
                   : {8'h00, req_wdata[7:0]};
          cs_n_d = `AMI_CS_IDLE;
          cs_n_d[req_region] = 1'b0;
          rw_d = ~req_write;
          doe_d = req_write;
          cnt_d = phase_len(region_async_config[req_region], `AMI_CFG_SETUP_LSB);
          ready_d = 1'b0;
          state_d = ami_pkg::AMI_SETUP;
        end
      end
      ami_pkg::AMI_SETUP: begin
        cnt_d = cnt_q - `AMI_ONE_PHASE;
        if (cnt_q == `AMI_ONE_PHASE) begin
          oe_n_d = wr_q;
          we_n_d = ~wr_q;
          cnt_d = phase_len(cfg_q, `AMI_CFG_STROBE_LSB);
          state_d = ami_pkg::AMI_STROBE;
        end
      end
      ami_pkg::AMI_STROBE: begin
        cnt_d = cnt_q - `AMI_ONE_PHASE;
        if (cnt_q == `AMI_ONE_PHASE) begin
          if (cfg_q[`AMI_CFG_EW_BIT] && wait_act) begin
            tmo_d = 16'(WAIT_TIMEOUT_CYC);
            state_d = ami_pkg::AMI_EXT_WAIT;
          end else begin
            rdat_d = wide ? ext_data_in : {8'h00, ext_data_in[7:0]};
            oe_n_d = 1'b1;
            we_n_d = 1'b1;
            cnt_d = phase_len(cfg_q, `AMI_CFG_HOLD_LSB);
            tmo_flag_d = 1'b0;
            state_d = ami_pkg::AMI_HOLD;
          end
        end
      end
      ami_pkg::AMI_EXT_WAIT: begin
        // Strobe stays low while wait is active; timeout stops a stuck device
        tmo_d = tmo_q - 16'h0001;
        if (!wait_act || tmo_q == 16'h0001) begin
          rdat_d = wide ? ext_data_in : {8'h00, ext_data_in[7:0]};
          tmo_flag_d = wait_act;
          oe_n_d = 1'b1;
          we_n_d = 1'b1;
          cnt_d = phase_len(cfg_q, `AMI_CFG_HOLD_LSB);
          state_d = ami_pkg::AMI_HOLD;
        end
      end
      ami_pkg::AMI_HOLD: begin
        cnt_d = cnt_q - `AMI_ONE_PHASE;
        if (cnt_q == `AMI_ONE_PHASE) begin
          cs_n_d = `AMI_CS_IDLE;
          doe_d = 1'b0;
          rw_d = 1'b1;
          rv_d = 1'b1;
          ready_d = 1'b1;
          state_d = ami_pkg::AMI_IDLE;
        end
      end
      default: state_d = ami_pkg::AMI_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ami_pkg::AMI_IDLE;
      cnt_q <= '0;
      tmo_q <= '0;
      reg_q <= '0;
      wr_q <= 1'b0;
      cfg_q <= `AMI_CFG_RESET;
      addr_q <= '0;
      wdat_q <= '0;
      rdat_q <= '0;
      cs_n_q <= `AMI_CS_IDLE;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      rw_q <= 1'b1;
      doe_q <= 1'b0;
      ready_q <= 1'b1;
      rv_q <= 1'b0;
      tmo_flag_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      tmo_q <= tmo_d;
      reg_q <= reg_d;
      wr_q <= wr_d;
      cfg_q <= cfg_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      cs_n_q <= cs_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      rw_q <= rw_d;
      doe_q <= doe_d;
      ready_q <= ready_d;
      rv_q <= rv_d;
      tmo_flag_q <= tmo_flag_d;
    end
  end

  assign req_ready = ready_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rdat_q;
  assign rsp_timeout = tmo_flag_q;
  assign ext_addr_bus = addr_q;
  assign ext_data_out = wdat_q;
  assign ext_data_oe = doe_q;
  assign chip_enable_n = cs_n_q;
  assign read_strobe_n = oe_n_q;
  assign write_strobe_n = we_n_q;
  assign rd_wr_select = rw_q;

  one_cs_a: assert property (@(posedge clock) disable iff (reset)
    $countones(~chip_enable_n) <= 1) else $error("more than one chip enable low");
  strobe_excl_a: assert property (@(posedge clock) disable iff (reset)
    !(!read_strobe_n && !write_strobe_n)) else $error("both strobes low");
  strobe_dir_a: assert property (@(posedge clock) disable iff (reset)
    !write_strobe_n |-> !rd_wr_select && ext_data_oe) else $error("write strobe without write dir");
  read_dir_a: assert property (@(posedge clock) disable iff (reset)
    !read_strobe_n |-> rd_wr_select && !ext_data_oe) else $error("read strobe in write dir");
  strobe_cs_a: assert property (@(posedge clock) disable iff (reset)
    (!read_strobe_n || !write_strobe_n) |-> chip_enable_n != `AMI_CS_IDLE)
    else $error("strobe without chip enable");
  ew_hold_a: assert property (@(posedge clock) disable iff (reset)
    state_q == ami_pkg::AMI_EXT_WAIT && wait_act && tmo_q != 16'h0001 |=>
    state_q == ami_pkg::AMI_EXT_WAIT) else $error("strobe released while wait active");
  ew_gate_a: assert property (@(posedge clock) disable iff (reset)
    state_q == ami_pkg::AMI_EXT_WAIT |-> cfg_q[`AMI_CFG_EW_BIT])
    else $error("extended wait without enable bit");
  setup_len_a: assert property (@(posedge clock) disable iff (reset)
    state_q == ami_pkg::AMI_IDLE ##1 state_q == ami_pkg::AMI_SETUP && cnt_q == `AMI_ONE_PHASE
    |=> state_q == ami_pkg::AMI_STROBE) else $error("setup phase length wrong");
  narrow_a: assert property (@(posedge clock) disable iff (reset)
    rsp_valid && !cfg_q[`AMI_CFG_WIDE_BIT] |-> rsp_rdata[15:8] == 8'h00)
    else $error("narrow read upper byte not zero");
  addr_a: assert property (@(posedge clock) disable iff (reset)
    req_valid && req_ready |=> ext_addr_bus == $past(req_addr)) else $error("address not driven");

  rd_c: cover property (@(posedge clock) !read_strobe_n ##[1:40] rsp_valid);
  wr_c: cover property (@(posedge clock) !write_strobe_n ##[1:40] rsp_valid);
  ew_c: cover property (@(posedge clock) state_q == ami_pkg::AMI_EXT_WAIT [*3]);
  tmo_c: cover property (@(posedge clock) rsp_valid && rsp_timeout);
endmodule

// *** dv/ami_mem_model.sv ***
// Behavioural asynchronous memory, four regions, with per-region wait pins.
// Assumes the controller's pin ports and the bench clock.
`timescale 1ns/1ps
module ami_mem_model (
  // Clock
  input wire logic clock,
  // Controller pins
  input wire logic [3:0] chip_enable_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [23:0] ext_addr_bus,
  input wire logic [15:0] ext_data_out,
  output logic [15:0] ext_data_in,
  output logic [3:0] ext_wait_in,
  // Scenario knobs
  input wire logic [3:0] wait_pol,
  input wire logic [7:0] wait_len,
  input wire logic wait_other
);
  logic [15:0] mem [0:1023];
  logic [15:0] last_q = 16'h0000;
  logic [3:0] cs_q = 4'hf;
  logic [7:0] cnt_q = 8'h00;
  logic [1:0] rg;
  logic [1:0] wrg;
  logic sel;
  always_comb begin
    rg = 2'h0;
    for (int i = 0; i < 4; i++) if (!chip_enable_n[i]) rg = 2'(i);
    sel = (chip_enable_n != 4'hf);
    wrg = rg + {1'b0, wait_other};
  end
  // Released bus shows the inverse of the last word, so stale data cannot pass
  assign ext_data_in = (sel && !read_strobe_n) ? mem[{rg, ext_addr_bus[7:0]}] : ~last_q;
  always @(posedge clock) begin
    cs_q <= chip_enable_n;
    if (sel && !read_strobe_n) last_q <= mem[{rg, ext_addr_bus[7:0]}];
    if (sel && !write_strobe_n) mem[{rg, ext_addr_bus[7:0]}] <= ext_data_out;
    if (cs_q == 4'hf && sel) cnt_q <= wait_len;
    else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
  end
  // Wait only while selected; other pins rest at their inactive level
  always_comb begin
    ext_wait_in = ~wait_pol;
    if (sel && cnt_q != 8'h00) ext_wait_in[wrg] = wait_pol[wrg];
  end
endmodule

// *** dv/tb_async_memory_interface.sv ***
// Self-checking bench for ami_ctrl against a behavioural memory.
// Assumes the design files and ami_mem_model are compiled first.
`timescale 1ns/1ps
module tb_async_memory_interface;
  typedef struct {logic [15:0] d; int lat; int mode; bit chk_d; logic to; int t;} ami_note_s;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, req_ready, rsp_valid, rsp_timeout;
  logic [1:0] req_region = 2'h0;
  logic [23:0] req_addr = 24'h000000, ext_addr_bus;
  logic [15:0] req_wdata = 16'h0000, rsp_rdata, ext_data_in, ext_data_out;
  logic [3:0][14:0] cfg = {4{15'h4221}};
  logic [3:0] chip_enable_n, ext_wait_in, wait_pol = 4'h0;
  logic ext_data_oe, read_strobe_n, write_strobe_n, rd_wr_select, wait_other = 1'b0;
  logic [7:0] wait_len = 8'h00;
  logic [14:0] c;
  logic [15:0] shadow [0:1023];
  int seed = 32'h8647d353;
  int cyc = 0, num_errors = 0, n_compared = 0;
  ami_note_s notes[$];
  ami_note_s nt;
  always #5 clock = ~clock;
  ami_ctrl #(.WAIT_TIMEOUT_CYC(32)) dut (.clock(clock), .reset(reset), .req_valid(req_valid),
    .req_write(req_write), .req_region(req_region), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout), .region_async_config(cfg),
    .ext_addr_bus(ext_addr_bus), .ext_data_in(ext_data_in), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .chip_enable_n(chip_enable_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .rd_wr_select(rd_wr_select), .ext_wait_in(ext_wait_in));
  ami_mem_model mem (.clock(clock), .chip_enable_n(chip_enable_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .ext_addr_bus(ext_addr_bus), .ext_data_out(ext_data_out), .ext_data_in(ext_data_in),
    .ext_wait_in(ext_wait_in), .wait_pol(wait_pol), .wait_len(wait_len),
    .wait_other(wait_other));
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t value %h, expected %h", $time, seen, exp);
    end
  endtask
  function automatic int eff(input logic [3:0] v);
    return (v == 4'h0) ? 1 : int'(v);
  endfunction
  // Mode 0 exact latency, 1 stretched, 2 stuck wait ending in timeout
  task automatic acc(input logic wr, input logic [1:0] rg, input logic [7:0] a,
      input logic [14:0] cf, input int mode);
    ami_note_s w;
    logic [15:0] d;
    d = 16'($random(seed));
    if (wr) shadow[{rg, a}] = cf[14] ? d : {8'h00, d[7:0]};
    w.d = shadow[{rg, a}];
    // Take edge to the edge that samples the response pulse: S+T+H+1
    w.lat = eff(cf[3:0]) + eff(cf[7:4]) + eff(cf[11:8]) + 1;
    w.mode = mode;
    w.chk_d = !wr;
    w.to = (mode == 2);
    @(posedge clock);
    cfg[rg] <= cf;
    wait_pol[rg] <= cf[13];
    req_valid <= 1'b1;
    req_write <= wr;
    req_region <= rg;
    req_addr <= {16'($random(seed)), a};
    req_wdata <= d;
    do @(posedge clock); while (req_ready !== 1'b1);
    w.t = cyc;
    notes.push_back(w);
    req_valid <= 1'b0;
  endtask
  task automatic drain();
    while (notes.size() != 0) @(posedge clock);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      num_errors++;
      close_out();
    end
    if (reset && cyc > 1) chk(chip_enable_n, 4'hf);
    if (!reset) begin
      chk($countones(~chip_enable_n) <= 1, 1);
      if (read_strobe_n === 1'b0) chk({rd_wr_select, ext_data_oe}, 2'b10);
      if (write_strobe_n === 1'b0) chk({rd_wr_select, ext_data_oe}, 2'b01);
    end
    if (rsp_valid === 1'b1 && notes.size() == 0) chk(1'b0, 1'b1);
    else if (rsp_valid === 1'b1) begin
      nt = notes.pop_front();
      chk(rsp_timeout, nt.to);
      if (nt.chk_d) chk(rsp_rdata, nt.d);
      if (nt.mode == 0) chk(cyc - nt.t, nt.lat);
      if (nt.mode == 1) chk(cyc - nt.t > nt.lat, 1);
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      c = {i[2], 1'($random(seed)), 1'b0, 12'($random(seed)) & 12'h333};
      acc(1'b1, i[1:0], i[7:0], c, 0);
      acc(1'b0, i[1:0], i[7:0], c, 0);
    end
    drain();
    wait_len <= 8'h06;
    for (int p = 0; p < 2; p++) begin
      c = {1'b1, p[0], 1'b1, 12'h141};
      acc(1'b1, 2'(p + 1), 8'h40, c, 1);
      acc(1'b0, 2'(p + 1), 8'h40, c, 1);
    end
    acc(1'b0, 2'h1, 8'h40, 15'h4141, 0);
    drain();
    wait_other <= 1'b1;
    acc(1'b0, 2'h2, 8'h40, 15'h5141, 0);
    drain();
    wait_other <= 1'b0;
    wait_len <= 8'hc8;
    acc(1'b1, 2'h3, 8'h50, 15'h5141, 2);
    drain();
    close_out();
  end
endmodule
